/* File: hdl/pps_pkg.sv */
// Package: register map, field layout and codes of the port status block
package pps_pkg;

    // ****************************************
    // Bus
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] STATUS_INDEX = 8'h1A;
    localparam logic [7:0] STATUS_ADDR = 8'h68;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'h70;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h74;
    localparam logic [7:0] CONTROL_ADDR = 8'h78;
    localparam logic [7:0] THRESH_ADDR = 8'h7C;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int UNDER_BIT = 29;
    localparam int OVER_BIT = 28;
    localparam int SELF_TEST_BIT = 27;
    localparam int REDUCED_BIT = 26;
    localparam int NONNEG_LSB = 24;
    localparam int SUPPLIER_LSB = 22;
    localparam int LEVEL_LSB = 20;
    localparam int ORIGIN_LSB = 18;

    // ****************************************
    // Field codes
    // ****************************************
    localparam logic [1:0] NONNEG_NORMAL = 2'h0;
    localparam logic [1:0] NONNEG_LEGACY_SINK = 2'h1;
    localparam logic [1:0] NONNEG_LEGACY_SOURCE = 2'h2;
    localparam logic [1:0] SUPPLIER_NONE = 2'h0;
    localparam logic [1:0] SUPPLIER_PD_NO_USB = 2'h1;
    localparam logic [1:0] SUPPLIER_NON_PD = 2'h2;
    localparam logic [1:0] SUPPLIER_PD_USB = 2'h3;
    localparam logic [1:0] LEVEL_SAFE0V = 2'h0;
    localparam logic [1:0] LEVEL_SAFE5V = 2'h1;
    localparam logic [1:0] LEVEL_NEGOTIATED = 2'h2;
    localparam logic [1:0] LEVEL_OUTSIDE = 2'h3;
    localparam logic [1:0] ORIGIN_UNKNOWN = 2'h0;
    localparam logic [1:0] ORIGIN_AUX = 2'h1;
    localparam logic [1:0] ORIGIN_DEAD_BATTERY = 2'h2;
    localparam logic [1:0] ORIGIN_VBUS = 2'h3;

    // Mode register codes reported alongside the status word
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_SELF_TEST = 4'h1;
    localparam logic [3:0] MODE_REDUCED = 4'h2;

    // VBUS level limits in millivolts
    localparam logic [15:0] SAFE0V_MAX_MV = 16'h0320;
    localparam logic [15:0] SAFE5V_MIN_MV = 16'h128E;
    localparam logic [15:0] SAFE5V_MAX_MV = 16'h157C;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] LOW_THRESH_RESET = 16'h128E;
    localparam logic [15:0] HIGH_THRESH_RESET = 16'h157C;
    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
    localparam logic [2:0] CONTROL_RESET = 3'h0;

    // Interrupt event bits
    localparam int EV_UNDER = 0;
    localparam int EV_OVER = 1;
    localparam int EV_SELF_TEST = 2;
    localparam int EV_REDUCED = 3;
    localparam int EV_NONNEG = 4;
    localparam int EV_LEVEL = 5;
    localparam int EV_SUPPLIER = 6;
    localparam int EV_ORIGIN = 7;
    localparam int EV_W = 8;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic write;
        logic read;
        logic [ADDR_W-1:0] address;
        logic [3:0] byteenable;
        logic [DATA_W-1:0] writedata;
    } pps_avs_req_type;

    typedef struct packed {
        logic is_source;
        logic is_sink;
        logic connected;
        logic contract;
        logic self_test_run;
        logic min_received;
        logic min_sent;
        logic src_caps_received;
        logic hard_reset;
        logic far_supplies;
        logic far_is_pd;
        logic far_usb;
        logic dead_battery;
        logic aux_powered;
        logic vbus_powered;
        logic [15:0] vbus_mv;
        logic [15:0] negotiated_min_mv;
        logic [15:0] negotiated_max_mv;
    } pps_port_state_type;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } pps_msg_type;

endpackage

/* File: hdl/pps_port_status.sv */
// Port status upper fields with Avalon-MM register slave and interrupt
`timescale 1ns/1ps

module pps_port_status
    import pps_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Avalon-MM slave
    input wire pps_pkg::pps_avs_req_type i_avs_req,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Port state from policy and measurement logic
    input wire pps_pkg::pps_port_state_type i_port,
    // Received PD messages
    input wire pps_pkg::pps_msg_type i_rx_msg,
    // Messages passed on to the protocol engine
    output pps_pkg::pps_msg_type o_rx_msg,
    // Operating mode code
    output logic [3:0] o_mode_code,
    // Interrupt
    output logic o_irq
);
    import pps_pkg::*;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_ACK = 3'b010,
        BUS_DONE = 3'b100
    } pps_bus_state_type;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [1:0] level_class(input logic [15:0] mv, input logic [15:0] lo, input logic [15:0] hi);
        if (mv < SAFE0V_MAX_MV) begin
            level_class = LEVEL_SAFE0V;
        end else if (mv >= SAFE5V_MIN_MV && mv <= SAFE5V_MAX_MV) begin
            level_class = LEVEL_SAFE5V;
        end else if (mv >= lo && mv <= hi) begin
            level_class = LEVEL_NEGOTIATED;
        end else begin
            level_class = LEVEL_OUTSIDE;
        end
    endfunction

    logic [15:0] low_thresh_reg;
    logic [15:0] high_thresh_reg;
    logic [2:0] control_reg;
    logic [EV_W-1:0] irq_status_reg;
    logic [EV_W-1:0] irq_mask_reg;
    logic under_reg;
    logic over_reg;
    logic self_test_reg;
    logic reduced_reg;
    logic [1:0] nonneg_reg;
    logic [1:0] supplier_reg;
    logic [1:0] level_reg;
    logic [1:0] origin_reg;
    logic [31:0] status_word;
    pps_bus_state_type bus_state_reg;
    logic wr_hit;

    // ****************************************
    // Status fields
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            under_reg <= 1'b0;
            over_reg <= 1'b0;
        end else begin
            under_reg <= i_port.connected && i_port.is_source && (i_port.vbus_mv < low_thresh_reg);
            over_reg <= i_port.connected && i_port.is_source && (i_port.vbus_mv > high_thresh_reg);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            self_test_reg <= 1'b0;
        end else begin
            self_test_reg <= i_port.self_test_run;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            reduced_reg <= 1'b0;
        end else if (!i_port.contract || !i_port.connected || i_port.hard_reset || i_port.src_caps_received) begin
            reduced_reg <= 1'b0;
        end else if ((i_port.min_received && i_port.is_sink) || (i_port.min_sent && i_port.is_source)) begin
            reduced_reg <= 1'b1;
        end
    end

    // Legacy mode chosen by software control bits
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            nonneg_reg <= NONNEG_NORMAL;
        end else if (control_reg[1:0] == NONNEG_LEGACY_SINK || control_reg[1:0] == NONNEG_LEGACY_SOURCE) begin
            nonneg_reg <= control_reg[1:0];
        end else begin
            nonneg_reg <= NONNEG_NORMAL;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            supplier_reg <= SUPPLIER_NONE;
        end else if (!i_port.far_supplies || i_port.is_source) begin
            supplier_reg <= SUPPLIER_NONE;
        end else if (!i_port.far_is_pd) begin
            supplier_reg <= SUPPLIER_NON_PD;
        end else begin
            supplier_reg <= i_port.far_usb ? SUPPLIER_PD_USB : SUPPLIER_PD_NO_USB;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            level_reg <= LEVEL_SAFE0V;
        end else begin
            level_reg <= level_class(i_port.vbus_mv, i_port.negotiated_min_mv, i_port.negotiated_max_mv);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            origin_reg <= ORIGIN_UNKNOWN;
        end else if (i_port.dead_battery) begin
            origin_reg <= ORIGIN_DEAD_BATTERY;
        end else if (i_port.aux_powered) begin
            origin_reg <= ORIGIN_AUX;
        end else if (i_port.vbus_powered) begin
            origin_reg <= ORIGIN_VBUS;
        end else begin
            origin_reg <= ORIGIN_UNKNOWN;
        end
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[UNDER_BIT] = under_reg;
        status_word[OVER_BIT] = over_reg;
        status_word[SELF_TEST_BIT] = self_test_reg;
        status_word[REDUCED_BIT] = reduced_reg;
        status_word[NONNEG_LSB +: 2] = nonneg_reg;
        status_word[SUPPLIER_LSB +: 2] = supplier_reg;
        status_word[LEVEL_LSB +: 2] = level_reg;
        status_word[ORIGIN_LSB +: 2] = origin_reg;
    end

    // ****************************************
    // Mode code and message gate
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_mode_code <= MODE_NORMAL;
        end else if (i_port.self_test_run) begin
            o_mode_code <= MODE_SELF_TEST;
        end else if (reduced_reg && i_port.is_source) begin
            o_mode_code <= MODE_REDUCED;
        end else begin
            o_mode_code <= MODE_NORMAL;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rx_msg <= '0;
        end else begin
            o_rx_msg.valid <= i_rx_msg.valid && (nonneg_reg == NONNEG_NORMAL);
            o_rx_msg.data <= i_rx_msg.data;
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    logic [31:0] prev_word_reg;
    logic [EV_W-1:0] change;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            prev_word_reg <= 32'h0000_0000;
        end else begin
            prev_word_reg <= status_word;
        end
    end

    always_comb begin
        change = '0;
        change[EV_UNDER] = prev_word_reg[UNDER_BIT] != status_word[UNDER_BIT];
        change[EV_OVER] = prev_word_reg[OVER_BIT] != status_word[OVER_BIT];
        change[EV_SELF_TEST] = prev_word_reg[SELF_TEST_BIT] != status_word[SELF_TEST_BIT];
        change[EV_REDUCED] = prev_word_reg[REDUCED_BIT] != status_word[REDUCED_BIT];
        change[EV_NONNEG] = prev_word_reg[NONNEG_LSB +: 2] != status_word[NONNEG_LSB +: 2];
        change[EV_LEVEL] = prev_word_reg[LEVEL_LSB +: 2] != status_word[LEVEL_LSB +: 2];
        change[EV_SUPPLIER] = prev_word_reg[SUPPLIER_LSB +: 2] != status_word[SUPPLIER_LSB +: 2];
        change[EV_ORIGIN] = prev_word_reg[ORIGIN_LSB +: 2] != status_word[ORIGIN_LSB +: 2];
    end

    assign wr_hit = (bus_state_reg == BUS_ACK) && i_avs_req.write;

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            irq_status_reg <= '0;
        end else if (wr_hit && i_avs_req.address == IRQ_STATUS_ADDR && i_avs_req.byteenable[0]) begin
            irq_status_reg <= (irq_status_reg & ~i_avs_req.writedata[EV_W-1:0]) | change;
        end else begin
            irq_status_reg <= irq_status_reg | change;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // ****************************************
    // Writable registers
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            irq_mask_reg <= IRQ_MASK_RESET;
            control_reg <= CONTROL_RESET;
            low_thresh_reg <= LOW_THRESH_RESET;
            high_thresh_reg <= HIGH_THRESH_RESET;
        end else if (wr_hit) begin
            unique case (i_avs_req.address)
                IRQ_MASK_ADDR: begin
                    if (i_avs_req.byteenable[0]) irq_mask_reg <= i_avs_req.writedata[EV_W-1:0];
                end
                CONTROL_ADDR: begin
                    if (i_avs_req.byteenable[0]) control_reg <= i_avs_req.writedata[2:0];
                end
                THRESH_ADDR: begin
                    if (i_avs_req.byteenable[0]) low_thresh_reg[7:0] <= i_avs_req.writedata[7:0];
                    if (i_avs_req.byteenable[1]) low_thresh_reg[15:8] <= i_avs_req.writedata[15:8];
                    if (i_avs_req.byteenable[2]) high_thresh_reg[7:0] <= i_avs_req.writedata[23:16];
                    if (i_avs_req.byteenable[3]) high_thresh_reg[15:8] <= i_avs_req.writedata[31:24];
                end
                default: begin
                    // Status word and unmapped addresses ignore writes
                end
            endcase
        end
    end

    // ****************************************
    // Bus handshake: one wait cycle, then release
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            bus_state_reg <= BUS_IDLE;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h0000_0000;
        end else begin
            unique case (bus_state_reg)
                BUS_IDLE: begin
                    o_avs_waitrequest <= 1'b1;
                    if (i_avs_req.read || i_avs_req.write) begin
                        bus_state_reg <= BUS_ACK;
                        o_avs_waitrequest <= 1'b0;
                        unique case (i_avs_req.address)
                            STATUS_ADDR: o_avs_readdata <= status_word;
                            IRQ_STATUS_ADDR: o_avs_readdata <= {24'h00_0000, irq_status_reg};
                            IRQ_MASK_ADDR: o_avs_readdata <= {24'h00_0000, irq_mask_reg};
                            CONTROL_ADDR: o_avs_readdata <= {29'h0000_0000, control_reg};
                            THRESH_ADDR: o_avs_readdata <= {high_thresh_reg, low_thresh_reg};
                            default: o_avs_readdata <= UNMAPPED_DATA;
                        endcase
                    end
                end
                BUS_ACK: begin
                    bus_state_reg <= BUS_DONE;
                    o_avs_waitrequest <= 1'b1;
                end
                BUS_DONE: begin
                    bus_state_reg <= BUS_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

endmodule

/* File: bench/pps_host_model.sv */
// Host processor model: Avalon-MM master for register accesses
`timescale 1ns/1ps

module pps_host_model
    import pps_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Avalon-MM master side
    output pps_pkg::pps_avs_req_type o_req,
    input wire logic [31:0] i_rdata,
    input wire logic i_wait
);
    initial o_req = '0;

    // One access; held until waitrequest is sampled low
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        o_req <= '{write: w, read: !w, address: a, byteenable: 4'hF, writedata: d};
        @(posedge i_clk);
        while (i_wait !== 1'h0) begin
            @(posedge i_clk);
        end
        q = i_rdata;
        o_req <= '0;
        @(posedge i_clk);
    endtask
endmodule

/* File: bench/pps_port_status_assertions.sv */
// Concurrent checks on the port status block ports
`timescale 1ns/1ps

module pps_port_status_assertions
    import pps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire pps_pkg::pps_avs_req_type i_avs_req,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire pps_pkg::pps_port_state_type i_port,
    input wire pps_pkg::pps_msg_type i_rx_msg,
    input wire pps_pkg::pps_msg_type o_rx_msg,
    input wire logic [3:0] o_mode_code,
    input wire logic o_irq
);
    wire logic rd_st;
    assign rd_st = !o_avs_waitrequest && i_avs_req.read && (i_avs_req.address == STATUS_ADDR);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_reserved_zero: assert property (rd_st |-> o_avs_readdata[31:30] == 2'h0)
        else $error("reserved status bits not zero");
    a_under_src_only: assert property (rd_st && !($past(i_port.is_source, 2) && $past(i_port.connected, 2))
        |-> !o_avs_readdata[UNDER_BIT])
        else $error("under-limit warning outside source role");
    a_over_src_only: assert property (rd_st && !($past(i_port.is_source, 2) && $past(i_port.connected, 2))
        |-> !o_avs_readdata[OVER_BIT])
        else $error("over-limit warning outside source role");
    a_self_test_bit: assert property (rd_st |-> o_avs_readdata[SELF_TEST_BIT] == $past(i_port.self_test_run, 2))
        else $error("self-test bit differs from running test");
    a_self_test_mode: assert property (!$past(i_reset) && $past(i_port.self_test_run) |-> o_mode_code == MODE_SELF_TEST)
        else $error("mode code not self-test");
    a_nonneg_legal: assert property (rd_st |-> o_avs_readdata[25:24] != 2'h3)
        else $error("reserved non-negotiating code reported");
    a_supplier_source: assert property (rd_st && $past(i_port.is_source, 2) |-> o_avs_readdata[23:22] == SUPPLIER_NONE)
        else $error("supplier field nonzero while source");
    a_level_safe0: assert property (rd_st && ($past(i_port.vbus_mv, 2) < SAFE0V_MAX_MV)
        |-> o_avs_readdata[21:20] == LEVEL_SAFE0V)
        else $error("level not safe zero below limit");
    a_origin_dead: assert property (rd_st && $past(i_port.dead_battery, 2)
        |-> o_avs_readdata[19:18] == ORIGIN_DEAD_BATTERY)
        else $error("origin not dead battery while flag set");
    a_rx_forward: assert property (o_rx_msg.valid |-> $past(i_rx_msg.valid) && o_rx_msg.data == $past(i_rx_msg.data))
        else $error("forwarded message without a received one");
endmodule

bind pps_port_status pps_port_status_assertions chk_i (.i_clk(i_clk), .i_reset(i_reset),
    .i_avs_req(i_avs_req), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_port(i_port), .i_rx_msg(i_rx_msg), .o_rx_msg(o_rx_msg), .o_mode_code(o_mode_code), .o_irq(o_irq));

/* File: bench/tb_top.sv */
// Self-checking testbench for the port status block
`timescale 1ns/1ps

module tb_top;
    import pps_pkg::*;
    logic clk = 1'h0;
    logic rst = 1'h1;
    pps_avs_req_type req;
    pps_port_state_type port = '0;
    pps_msg_type rx = '0;
    pps_msg_type rx_out;
    logic [31:0] rdata;
    logic wait_req;
    logic [3:0] mode;
    logic irq;
    logic [31:0] sw;
    int err_total = 0;
    int n_compared = 0;

    always #4 clk = ~clk;

    pps_port_status dut (.i_clk(clk), .i_reset(rst), .i_avs_req(req), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wait_req), .i_port(port), .i_rx_msg(rx), .o_rx_msg(rx_out),
        .o_mode_code(mode), .o_irq(irq));
    pps_host_model host (.i_clk(clk), .o_req(req), .i_rdata(rdata), .i_wait(wait_req));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic close_out;
        if (err_total == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic rd(input logic [7:0] a);
        host.xfer(1'h0, a, 32'h0, sw);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'h1, a, d, q);
    endtask

    task automatic rd_st;
        repeat (2) @(posedge clk);
        rd(STATUS_ADDR);
    endtask

    task automatic pset(input logic src, input logic con, input logic [15:0] mv);
        port.is_source <= src;
        port.is_sink <= !src;
        port.connected <= con;
        port.vbus_mv <= mv;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs;
        logic [31:0] prev;
        rd(THRESH_ADDR);
        chk("thresh_reset", sw, {HIGH_THRESH_RESET, LOW_THRESH_RESET});
        rd(STATUS_ADDR);
        prev = sw;
        wr(STATUS_ADDR, 32'hFFFF_FFFF);
        rd(STATUS_ADDR);
        chk("status_ro", sw, prev);
        rd(8'h40);
        chk("unmapped", sw, UNMAPPED_DATA);
    endtask

    task automatic t_warn;
        logic [15:0] mv [4] = '{16'h0FA0, 16'h1770, 16'h0FA0, 16'h1770};
        logic [1:0] pc [4] = '{2'h3, 2'h3, 2'h1, 2'h2};
        logic [1:0] ex [4] = '{2'h2, 2'h1, 2'h0, 2'h0};
        for (int i = 0; i < 4; i++) begin
            pset(pc[i][1], pc[i][0], mv[i]);
            rd_st();
            chk("warn", sw[29:28], ex[i]);
        end
        wr(THRESH_ADDR, {16'h1770, 16'h1000});
        pset(1'h1, 1'h1, 16'h1068);
        rd_st();
        chk("warn_prog", sw[29:28], 2'h0);
    endtask

    task automatic t_level;
        logic [15:0] mv [5] = '{16'h01F4, 16'h0320, 16'h1388, 16'h2328, 16'h2EE0};
        logic [1:0] cd [5] = '{LEVEL_SAFE0V, LEVEL_OUTSIDE, LEVEL_SAFE5V, LEVEL_NEGOTIATED, LEVEL_OUTSIDE};
        port.negotiated_min_mv <= 16'h2134;
        port.negotiated_max_mv <= 16'h251C;
        for (int i = 0; i < 5; i++) begin
            pset(1'h0, 1'h1, mv[i]);
            rd_st();
            chk("level", sw[21:20], cd[i]);
        end
    endtask

    task automatic t_self;
        for (int i = 1; i >= 0; i--) begin
            port.self_test_run <= i[0];
            rd_st();
            chk("self_test", sw[SELF_TEST_BIT], i[0]);
            chk("mode_test", mode, i[0] ? MODE_SELF_TEST : MODE_NORMAL);
        end
    endtask

    task automatic t_reduced;
        port.contract <= 1'h1;
        port.min_received <= 1'h1;
        @(posedge clk);
        port.min_received <= 1'h0;
        rd_st();
        chk("reduced_sink", sw[REDUCED_BIT], 1'h1);
        port.src_caps_received <= 1'h1;
        @(posedge clk);
        port.src_caps_received <= 1'h0;
        rd_st();
        chk("reduced_caps", sw[REDUCED_BIT], 1'h0);
        pset(1'h1, 1'h1, 16'h1388);
        port.min_sent <= 1'h1;
        @(posedge clk);
        port.min_sent <= 1'h0;
        rd_st();
        chk("reduced_src", sw[REDUCED_BIT], 1'h1);
        chk("mode_reduced", mode, MODE_REDUCED);
        port.hard_reset <= 1'h1;
        @(posedge clk);
        port.hard_reset <= 1'h0;
        rd_st();
        chk("reduced_hard", sw[REDUCED_BIT], 1'h0);
        port.contract <= 1'h0;
        port.min_sent <= 1'h1;
        @(posedge clk);
        port.min_sent <= 1'h0;
        rd_st();
        chk("reduced_none", sw[REDUCED_BIT], 1'h0);
    endtask

    task automatic t_legacy;
        logic [1:0] ex [3] = '{NONNEG_LEGACY_SINK, NONNEG_LEGACY_SOURCE, NONNEG_NORMAL};
        for (int i = 0; i < 3; i++) begin
            wr(CONTROL_ADDR, 32'(i + 1));
            rd_st();
            chk("nonneg", sw[25:24], ex[i]);
            rx <= '{valid: 1'h1, data: 8'hA5};
            @(posedge clk);
            rx <= '0;
            @(negedge clk);
            chk("rx_pass", rx_out.valid, ex[i] == NONNEG_NORMAL);
            chk("rx_data", rx_out.data, 8'hA5);
            @(posedge clk);
        end
    endtask

    task automatic t_codes;
        logic [2:0] sp [4] = '{3'h4, 3'h6, 3'h7, 3'h0};
        logic [1:0] se [4] = '{SUPPLIER_NON_PD, SUPPLIER_PD_NO_USB, SUPPLIER_PD_USB, SUPPLIER_NONE};
        logic [1:0] oe [4] = '{ORIGIN_DEAD_BATTERY, ORIGIN_AUX, ORIGIN_VBUS, ORIGIN_UNKNOWN};
        pset(1'h0, 1'h1, 16'h1388);
        for (int i = 0; i < 4; i++) begin
            {port.far_supplies, port.far_is_pd, port.far_usb} <= sp[i];
            {port.dead_battery, port.aux_powered, port.vbus_powered} <= 3'h7 >> i;
            rd_st();
            chk("supplier", sw[23:22], se[i]);
            chk("origin", sw[19:18], oe[i]);
        end
        {port.far_supplies, port.far_is_pd, port.far_usb} <= 3'h7;
        pset(1'h1, 1'h1, 16'h1388);
        rd_st();
        chk("supplier_src", sw[23:22], SUPPLIER_NONE);
    endtask

    task automatic t_irq;
        wr(IRQ_MASK_ADDR, 32'h0);
        wr(IRQ_STATUS_ADDR, 32'hFF);
        port.self_test_run <= 1'h1;
        repeat (4) @(posedge clk);
        chk("irq_masked", irq, 1'h0);
        rd(IRQ_STATUS_ADDR);
        chk("irq_status", sw[EV_SELF_TEST], 1'h1);
        wr(IRQ_MASK_ADDR, 32'h4);
        repeat (2) @(posedge clk);
        chk("irq_on", irq, 1'h1);
        wr(IRQ_STATUS_ADDR, 32'h4);
        repeat (3) @(posedge clk);
        chk("irq_clear", irq, 1'h0);
    endtask

    // ****************************************
    // Sequence and watchdog
    // ****************************************
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        t_regs();
        t_warn();
        t_level();
        t_self();
        t_reduced();
        t_legacy();
        t_codes();
        t_irq();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out();
    end
endmodule
